// ===== shared/ppcr_consts.vh
// constants for the protected power control register bank
// assumes inclusion by bare name from design files
`ifndef PPCR_CONSTS_VH
`define PPCR_CONSTS_VH
`define PPCR_OFS_PCON_TWO      8'h44
`define PPCR_OFS_PCON_THREE    8'h45
`define PPCR_OFS_LOCK_CTRL     8'h48
`define PPCR_ADDR_HIGH_PAGE_P  8'h00
`define PPCR_MODE_STANDBY      8'h00
`define PPCR_MODE_PAGE_WRITE   8'h04
`define PPCR_MODE_PAGE_READ    8'h05
`define PPCR_TRIG_FIRST        8'h46
`define PPCR_TRIG_SECOND       8'hb9
`define PPCR_RST_PCON_TWO      8'h05
`define PPCR_RST_PCON_THREE    8'h01
`define PPCR_RST_LOCK_CTRL     8'h00
`define PPCR_MASK_PCON_THREE   8'h09
`define PPCR_MASK_LOCK_CTRL    8'h7f
`define PPCR_BIT_HSE           7
`define PPCR_BIT_EXEC_LOCK     6
`define PPCR_BIT_LVL_HI        5
`define PPCR_BIT_LVL_LO        4
`define PPCR_BIT_D1_RST        3
`define PPCR_BIT_D1_EN         2
`define PPCR_BIT_D0_RST        1
`define PPCR_BIT_D1_KEEP       3
`define PPCR_BIT_DEBUG         0
`define PPCR_LOCK_P6           6
`define PPCR_LOCK_P4           5
`define PPCR_LOCK_WDT          4
`define PPCR_LOCK_CK1          3
`define PPCR_LOCK_CK0          2
`define PPCR_LOCK_PW1          1
`define PPCR_LOCK_PW0          0
`define PPCR_PAGE_ONE          4'h1
`define PPCR_OFS_COPY_CK0      8'h41
`define PPCR_OFS_COPY_CK1      8'h42
`define PPCR_OFS_COPY_PW0      8'h43
`define PPCR_OFS_COPY_PW1      8'h4c
`define PPCR_OFS_COPY_P4       8'h49
`define PPCR_OFS_COPY_P6       8'h4a
`define PPCR_OFS_COPY_WDT      8'h4b
`define PPCR_FORCE_PCON_TWO    8'h01
`endif

// ===== src/ppcr_regs.v
// protected-page power control, detector control and normal-page write locks
// assumes the flash-programming command logic drives the two-byte trigger
// in the same clock domain; detectors' analogue parts sit outside
`timescale 1ns/10ps
`include "ppcr_consts.vh"
// Operation
// RULE1 - bit 7 of power control two drives high-speed circuit enable
// RULE2 - bit 6 set blocks code execution from the data-flash region
// RULE3 - bits 5..4 pick detector-1 threshold 2.0, 2.4, 3.7 or 4.2 V
// RULE4 - detector-1 level field loads from option bits at reset
// RULE5 - bit 3 set lets detector-1 flag issue a system reset
// RULE6 - bit 2 enables detector 1; clear turns it off
// RULE7 - bit 1 set lets detector-0 flag issue a system reset
// RULE8 - software writes 1 to bit 0 of power control two
// RULE9 - power control three bit 3 keeps detector 1 running in power-down
// RULE10 - power control three bit 0 connects debug to port 4 pins 4 and 5
// RULE11 - software writes 0 to reserved bits of both registers
// RULE12 - lock bit 6 blocks port 6 writes from page 1, reads stay
// RULE13 - lock bit 5 blocks port 4 writes from normal pages
// RULE14 - lock bit 4 makes watchdog control read-only from normal pages
// RULE15 - lock bits 3 and 2 protect clock control one and zero
// RULE16 - lock bits 1 and 0 protect power control one and zero
// RULE17 - protected-page copies are always writable regardless of locks
// RULE18 - read sequence: high address 0, enable, mode 5, trigger, restore; this block has no read path and a mode-5 trigger does nothing
// RULE19 - write sequence: same trigger with mode 4, then standby and disable
// RULE20 - high address 0, low address selects; data loads on trigger
// RULE21 - locked normal writes are silently dropped, reads unaffected
module ppcr_regs (
  // clock and control
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  // option bits for the detector-1 level, from non-volatile storage
  input  wire [1:0] option_level,
  // flash-programming command interface
  input  wire       flash_prog_enable,
  input  wire [7:0] flash_op_mode,
  input  wire [7:0] flash_addr_high,
  input  wire [7:0] flash_addr_low,
  input  wire [7:0] flash_data_byte,
  input  wire       cmd_write,
  input  wire [7:0] flash_command_trigger,
  // normal-page special register write attempts
  input  wire [3:0] sfr_page,
  input  wire       wr_port4,
  input  wire       wr_port6,
  input  wire       wr_watchdog,
  input  wire       wr_clock0,
  input  wire       wr_clock1,
  input  wire       wr_power0,
  input  wire       wr_power1,
  // brown-out detector flags from the analogue side, and the power-down state
  input  wire       detector0_flag,
  input  wire       detector1_flag,
  input  wire       power_down,
  // controls out
  output reg        high_speed_enable,
  output reg        data_flash_exec_lockout,
  output reg  [1:0] detector1_level_select,
  output reg        detector1_active,
  output reg        debug_port_enable,
  output reg        brownout_reset,
  // protected-page write strobes for the locked registers' copies
  output reg        pp_wr_port4,
  output reg        pp_wr_port6,
  output reg        pp_wr_watchdog,
  output reg        pp_wr_clock0,
  output reg        pp_wr_clock1,
  output reg        pp_wr_power0,
  output reg        pp_wr_power1,
  output reg  [7:0] pp_wr_data,
  // gated normal-page write strobes
  output reg        en_wr_port4,
  output reg        en_wr_port6,
  output reg        en_wr_watchdog,
  output reg        en_wr_clock0,
  output reg        en_wr_clock1,
  output reg        en_wr_power0,
  output reg        en_wr_power1
);

  // protected-page offsets of the copies; the addresses are this block's own choice
  localparam [7:0] OFS_CK0 = `PPCR_OFS_COPY_CK0;
  localparam [7:0] OFS_CK1 = `PPCR_OFS_COPY_CK1;
  localparam [7:0] OFS_PW0 = `PPCR_OFS_COPY_PW0;
  localparam [7:0] OFS_PW1 = `PPCR_OFS_COPY_PW1;
  localparam [7:0] OFS_P4  = `PPCR_OFS_COPY_P4;
  localparam [7:0] OFS_P6  = `PPCR_OFS_COPY_P6;
  localparam [7:0] OFS_WDT = `PPCR_OFS_COPY_WDT;

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_ARMED = 2'b10;

  reg  [7:0] power_control_two;
  reg  [7:0] power_control_three;
  reg  [7:0] page_write_lock_control;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        fire;
  reg        d0_s1;
  reg        d0_s2;
  reg        d1_s1;
  reg        d1_s2;
  reg        pd_s1;
  reg        pd_s2;
  reg        d0_prev;
  reg        d1_prev;
  reg        opt_s1;
  reg        opt_s2;
  reg  [1:0] opt_a;
  reg  [1:0] opt_b;
  reg        load_opt;

  function sel;
    input [7:0] ofs;
    begin
      sel = fire && (flash_addr_low == ofs);
    end
  endfunction

  // rising edge of a synchronised flag; both sides come from flops
  function rise;
    input now_lvl;
    input was_lvl;
    begin
      rise = now_lvl & ~was_lvl;
    end
  endfunction

  // copy offset of each locked register, lane order as in the lock register
  function [7:0] copy_ofs;
    input integer idx;
    begin
      case (idx)
        `PPCR_LOCK_P6:  copy_ofs = OFS_P6;
        `PPCR_LOCK_P4:  copy_ofs = OFS_P4;
        `PPCR_LOCK_WDT: copy_ofs = OFS_WDT;
        `PPCR_LOCK_CK1: copy_ofs = OFS_CK1;
        `PPCR_LOCK_CK0: copy_ofs = OFS_CK0;
        `PPCR_LOCK_PW1: copy_ofs = OFS_PW1;
        default:        copy_ofs = OFS_PW0;
      endcase
    end
  endfunction

  // lanes in lock-register bit order: 6 port 6, 5 port 4, 4 watchdog,
  // 3 clock one, 2 clock zero, 1 power one, 0 power zero
  wire [6:0] wr_try = {wr_port6, wr_port4, wr_watchdog, wr_clock1, wr_clock0, wr_power1, wr_power0};
  wire [6:0] lock_hit;
  wire [6:0] next_en_wr;
  wire [6:0] next_pp_wr;
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gate_lane
      if (g == `PPCR_LOCK_P6) begin : page_one_only
        // port 6 lives in page 1 only, so its lock looks at the page
        assign lock_hit[g] = page_write_lock_control[g] & (sfr_page == `PPCR_PAGE_ONE); // RULE12
      end else begin : any_page
        // pages 0 to f are all normal pages, so no page test is needed
        assign lock_hit[g] = page_write_lock_control[g]; // RULE13 RULE14 RULE15 RULE16
      end
      // a locked attempt just vanishes: no error, and the read path is elsewhere
      assign next_en_wr[g] = wr_try[g] & ~lock_hit[g]; // RULE21
      // the protected-page copy ignores the lock; operands passed in full so the
      // assignment wakes up whenever fire or the address moves
      assign next_pp_wr[g] = fire && (flash_addr_low == copy_ofs(g)); // RULE17
    end
  endgenerate

  // two-byte trigger: a wrong second byte drops back to idle
  always @* begin
    next_state = state;
    fire = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cmd_write && flash_prog_enable && flash_command_trigger == `PPCR_TRIG_FIRST)
          next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (cmd_write) begin
          next_state = ST_IDLE;
          if (flash_prog_enable && flash_command_trigger == `PPCR_TRIG_SECOND &&
              flash_op_mode == `PPCR_MODE_PAGE_WRITE &&
              flash_addr_high == `PPCR_ADDR_HIGH_PAGE_P)
            fire = 1'b1; // RULE20
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // trigger state in its own process keeps the register updates below flat
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      power_control_two       <= `PPCR_RST_PCON_TWO;
      power_control_three     <= `PPCR_RST_PCON_THREE;
      page_write_lock_control <= `PPCR_RST_LOCK_CTRL;
      d0_s1 <= 1'b0;
      d0_s2 <= 1'b0;
      d1_s1 <= 1'b0;
      d1_s2 <= 1'b0;
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
      d0_prev <= 1'b0;
      d1_prev <= 1'b0;
      opt_s1 <= 1'b0;
      opt_s2 <= 1'b0;
      opt_a <= 2'b00;
      opt_b <= 2'b00;
      load_opt <= 1'b1;
      high_speed_enable       <= 1'b0;
      data_flash_exec_lockout <= 1'b0;
      detector1_level_select  <= 2'b00;
      detector1_active        <= 1'b0;
      debug_port_enable       <= 1'b0;
      brownout_reset          <= 1'b0;
      // the strobe outputs reset in their own process below
    end else if (ce) begin
      // option bits are pins from another domain
      opt_a <= option_level;
      opt_b <= opt_a;
      opt_s1 <= load_opt;
      opt_s2 <= opt_s1;
      d0_s1 <= detector0_flag;
      d0_s2 <= d0_s1;
      d1_s1 <= detector1_flag;
      d1_s2 <= d1_s1;
      pd_s1 <= power_down;
      pd_s2 <= pd_s1;
      d0_prev <= d0_s2;
      d1_prev <= d1_s2;
      // level field caught from option bits once synchroniser has settled
      if (opt_s2) begin
        power_control_two[`PPCR_BIT_LVL_HI:`PPCR_BIT_LVL_LO] <= opt_b; // RULE4
        load_opt <= 1'b0;
        opt_s1 <= 1'b0;
        opt_s2 <= 1'b0;
      end else if (sel(`PPCR_OFS_PCON_TWO)) begin
        // bit 0 is kept at 1 whatever software writes
        power_control_two <= flash_data_byte | `PPCR_FORCE_PCON_TWO; // RULE8
      end
      if (sel(`PPCR_OFS_PCON_THREE))
        power_control_three <= flash_data_byte & `PPCR_MASK_PCON_THREE; // RULE11
      if (sel(`PPCR_OFS_LOCK_CTRL))
        page_write_lock_control <= flash_data_byte & `PPCR_MASK_LOCK_CTRL; // RULE11
      high_speed_enable       <= power_control_two[`PPCR_BIT_HSE]; // RULE1
      data_flash_exec_lockout <= power_control_two[`PPCR_BIT_EXEC_LOCK]; // RULE2
      detector1_level_select  <= power_control_two[`PPCR_BIT_LVL_HI:`PPCR_BIT_LVL_LO]; // RULE3
      detector1_active <= power_control_two[`PPCR_BIT_D1_EN] &
                          (~pd_s2 | power_control_three[`PPCR_BIT_D1_KEEP]); // RULE6 RULE9
      debug_port_enable <= power_control_three[`PPCR_BIT_DEBUG]; // RULE10
      // reset pulse on the rising edge of a flag
      brownout_reset <= (rise(d1_s2, d1_prev) & power_control_two[`PPCR_BIT_D1_RST]) | // RULE5
                        (rise(d0_s2, d0_prev) & power_control_two[`PPCR_BIT_D0_RST]); // RULE7
    end
  end

  // one-clock strobes; every copy has an address of its own
  always @(posedge clk) begin
    if (srst) begin
      pp_wr_port4    <= 1'b0;
      pp_wr_port6    <= 1'b0;
      pp_wr_watchdog <= 1'b0;
      pp_wr_clock0   <= 1'b0;
      pp_wr_clock1   <= 1'b0;
      pp_wr_power0   <= 1'b0;
      pp_wr_power1   <= 1'b0;
      pp_wr_data     <= 8'h00;
      en_wr_port4    <= 1'b0;
      en_wr_port6    <= 1'b0;
      en_wr_watchdog <= 1'b0;
      en_wr_clock0   <= 1'b0;
      en_wr_clock1   <= 1'b0;
      en_wr_power0   <= 1'b0;
      en_wr_power1   <= 1'b0;
    end else if (ce) begin
      // protected copies ignore the locks
      pp_wr_data     <= flash_data_byte;
      pp_wr_port4    <= next_pp_wr[`PPCR_LOCK_P4]; // RULE17
      pp_wr_port6    <= next_pp_wr[`PPCR_LOCK_P6];
      pp_wr_watchdog <= next_pp_wr[`PPCR_LOCK_WDT];
      pp_wr_clock0   <= next_pp_wr[`PPCR_LOCK_CK0];
      pp_wr_clock1   <= next_pp_wr[`PPCR_LOCK_CK1];
      pp_wr_power0   <= next_pp_wr[`PPCR_LOCK_PW0];
      pp_wr_power1   <= next_pp_wr[`PPCR_LOCK_PW1];
      // dropped writes raise nothing; read paths are outside and untouched
      en_wr_port6    <= next_en_wr[`PPCR_LOCK_P6]; // RULE12 RULE21
      en_wr_port4    <= next_en_wr[`PPCR_LOCK_P4]; // RULE13
      en_wr_watchdog <= next_en_wr[`PPCR_LOCK_WDT]; // RULE14
      en_wr_clock1   <= next_en_wr[`PPCR_LOCK_CK1]; // RULE15
      en_wr_clock0   <= next_en_wr[`PPCR_LOCK_CK0]; // RULE15
      en_wr_power1   <= next_en_wr[`PPCR_LOCK_PW1]; // RULE16
      en_wr_power0   <= next_en_wr[`PPCR_LOCK_PW0]; // RULE16
    end
  end

endmodule

// ===== verif/ppcr_checker.sv
// port assertions for the protected power control bank
// assumes inputs change away from the rising edge; attempts drop while ce is low
`timescale 1ns/10ps
module ppcr_checker (
  input wire       clk, srst, ce, cmd_write, flash_prog_enable, wr_port4, wr_power0,
  input wire       high_speed_enable, data_flash_exec_lockout, debug_port_enable,
  input wire       brownout_reset, pp_wr_port4, en_wr_port4, en_wr_power0,
  input wire [1:0] detector1_level_select,
  input wire [7:0] flash_op_mode, flash_addr_high, flash_addr_low, flash_data_byte, flash_command_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !ce);
  wire go = flash_prog_enable && cmd_write && flash_command_trigger == 8'h46;
  wire arm = flash_prog_enable && cmd_write && flash_command_trigger == 8'hb9 && flash_op_mode == 8'h04
             && flash_addr_high == 8'h00;
  wire a44 = arm && flash_addr_low == 8'h44;
  wire a45 = arm && flash_addr_low == 8'h45;
  wire a49 = arm && flash_addr_low == 8'h49;
  a_hs_write: assert property (go ##1 a44 |->
    ##2 high_speed_enable == $past(flash_data_byte[7], 2)) else $error("high speed bit mismatch");
  a_lockout_write: assert property (go ##1 a44 |->
    ##2 data_flash_exec_lockout == $past(flash_data_byte[6], 2)) else $error("lockout bit mismatch");
  a_level_write: assert property (go ##1 a44 |->
    ##2 detector1_level_select == $past(flash_data_byte[5:4], 2)) else $error("level field mismatch");
  a_debug_write: assert property (go ##1 a45 |->
    ##2 debug_port_enable == $past(flash_data_byte[0], 2)) else $error("debug enable mismatch");
  a_hs_stable: assert property ($changed(high_speed_enable) |-> $past(a44, 2))
    else $error("high speed bit moved without a write");
  a_copy_strobe: assert property (pp_wr_port4 |-> $past(a49))
    else $error("copy strobe without trigger");
  a_gate_port4: assert property (en_wr_port4 |-> $past(wr_port4))
    else $error("port4 strobe without request");
  a_gate_power: assert property (en_wr_power0 |-> $past(wr_power0))
    else $error("power0 strobe without request");
  a_bor_pulse: assert property (brownout_reset |=> !brownout_reset)
    else $error("reset pulse too long");
endmodule
bind ppcr_regs ppcr_checker i_ppcr_checker (.clk, .srst, .ce, .cmd_write, .flash_prog_enable, .wr_port4, .wr_power0,
  .high_speed_enable, .data_flash_exec_lockout, .debug_port_enable, .brownout_reset, .pp_wr_port4,
  .en_wr_port4, .en_wr_power0, .detector1_level_select, .flash_op_mode, .flash_addr_high, .flash_addr_low,
  .flash_data_byte, .flash_command_trigger);

// ===== verif/tb_ppcr_regs.sv
// self-checking bench for the protected power control bank
// assumes the checker file is compiled with it; inputs move on falling edges
`timescale 1ns/10ps
module tb_ppcr_regs;
  reg         clk = 0, srst = 1, ce = 1, en = 0, cmd = 0, pd = 0, d0 = 0, d1 = 0;
  reg  [1:0]  opt = 0;
  reg  [3:0]  page = 0;
  reg  [6:0]  wv = 0, lk;
  reg  [7:0]  mode = 0, ah = 0, al = 0, db = 0, trig = 0, p2, v, w;
  reg  [55:0] cl = 56'h4a_494b_4241_4c43;
  wire        hs, lo, d1a, dbg, bor;
  wire [1:0]  lvl;
  wire [6:0]  pp, ev;
  wire [7:0]  ppd;
  integer     n_fail = 0, check_count = 0, cyc = 0, i, k, bors;
  ppcr_regs i_ppcr_regs (.clk(clk), .srst(srst), .ce(ce), .option_level(opt), .flash_prog_enable(en),
    .flash_op_mode(mode), .flash_addr_high(ah), .flash_addr_low(al), .flash_data_byte(db), .cmd_write(cmd),
    .flash_command_trigger(trig), .sfr_page(page), .wr_port6(wv[6]), .wr_port4(wv[5]), .wr_watchdog(wv[4]),
    .wr_clock1(wv[3]), .wr_clock0(wv[2]), .wr_power1(wv[1]), .wr_power0(wv[0]), .detector0_flag(d0),
    .detector1_flag(d1), .power_down(pd), .high_speed_enable(hs), .data_flash_exec_lockout(lo),
    .detector1_level_select(lvl), .detector1_active(d1a), .debug_port_enable(dbg), .brownout_reset(bor),
    .pp_wr_port6(pp[6]), .pp_wr_port4(pp[5]), .pp_wr_watchdog(pp[4]), .pp_wr_clock1(pp[3]),
    .pp_wr_clock0(pp[2]), .pp_wr_power1(pp[1]), .pp_wr_power0(pp[0]), .pp_wr_data(ppd),
    .en_wr_port6(ev[6]), .en_wr_port4(ev[5]), .en_wr_watchdog(ev[4]), .en_wr_clock1(ev[3]),
    .en_wr_clock0(ev[2]), .en_wr_power1(ev[1]), .en_wr_power0(ev[0]));
  initial forever #4 clk = ~clk;
  // port 6 lock only bites on page 1
  function [7:0] gated(input [6:0] wr, lock, input [3:0] pg);
    gated = {1'b0, wr & ~(lock & {pg == 4'h1, 6'h3f})};
  endfunction
  task chk(input string nm, input [7:0] seen, exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // two-byte trigger back to back; snapshots copy strobes and data
  task ppw(input [7:0] m, a, d, t2);
    begin
      en = 1; mode = m; al = a; db = d; cmd = 1; trig = 8'h46;
      tick(1);
      trig = t2;
      tick(1);
      // copy strobes stand only in the clock right after the trigger edge
      v = {1'b0, pp};
      w = ppd;
      cmd = 0;
      en = 0;
      tick(3);
    end
  endtask
  task flag(input a, b, input [7:0] e);
    begin
      bors = 0; d0 = a; d1 = b;
      repeat (8) begin
        @(posedge clk);
        #1 bors = bors + bor;
      end
      @(negedge clk);
      d0 = 0;
      d1 = 0;
      tick(4);
      chk("bor count", bors, e);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  initial begin
    v = $urandom(32'ha1ef_b358);
    opt = $urandom;
    tick(10);
    srst = 0;
    tick(8);
    chk("level at reset", lvl, opt);
    for (i = 0; i < 9; i = i + 1) begin
      p2 = (i == 8) ? 8'h0f : ($urandom | 8'h01);
      ppw(8'h04, 8'h44, p2, 8'hb9);
      chk("hse", hs, p2[7]);
      chk("lockout", lo, p2[6]);
      chk("level", lvl, p2[5:4]);
      chk("d1 active", d1a, p2[2]);
    end
    for (k = 0; k < 2; k = k + 1) begin
      ppw(8'h04, 8'h45, {4'h0, k[0], 2'b00, !k[0]}, 8'hb9);
      chk("debug", dbg, !k[0]);
      pd = 1;
      tick(5);
      chk("d1 in pd", d1a, k[0]);
      pd = 0;
      tick(5);
    end
    $display("test control done");
    ppw(8'h05, 8'h44, 8'h81, 8'hb9);
    ah = 8'h01;
    ppw(8'h04, 8'h44, 8'h81, 8'hb9);
    ah = 8'h00;
    ppw(8'h04, 8'h44, 8'h81, 8'h47);
    chk("refused", hs, 0);
    flag(1, 0, 1);
    flag(0, 1, 1);
    ppw(8'h04, 8'h44, 8'h05, 8'hb9);
    flag(1, 0, 0);
    flag(0, 1, 0);
    ce = 0;
    ppw(8'h04, 8'h44, 8'h85, 8'hb9);
    ce = 1;
    tick(2);
    chk("frozen hse", hs, 0);
    chk("frozen strobe", v, 0);
    $display("test refusal and brownout done");
    for (k = 0; k < 2; k = k + 1) begin
      lk = k ? 7'h7f : $urandom;
      ppw(8'h04, 8'h48, {1'b0, lk}, 8'hb9);
      for (i = 0; i < 8; i = i + 1) begin
        page = i[0] ? 4'h1 : $urandom;
        wv = $urandom;
        w = {1'b0, wv};
        tick(1);
        v = {1'b0, ev};
        wv = 0;
        chk("gated", v, gated(w[6:0], lk, page));
        tick(1);
      end
    end
    for (i = 0; i < 7; i = i + 1) begin
      k = $urandom;
      ppw(8'h04, cl[55-8*i -: 8], k[7:0], 8'hb9);
      chk("copy strobe", v, 8'h40 >> i);
      chk("copy data", w, k[7:0]);
    end
    $display("test locks and copies done");
    conclude;
  end
endmodule
